// ==== rtl/input_threshold_phase_regs.sv ====
// input start/stop thresholds, phase placement and current gain command registers
`timescale 1ns/1ps
module input_threshold_phase_regs (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic pmbus_clk,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_invalid,
    output logic rsp_denied,
    output logic rsp_unmapped,
    input wire logic [7:0] vin_quarter_v,
    input wire logic enable_ok,
    input wire logic stack_multi,
    input wire logic restore_req,
    input wire logic clear_status,
    input wire logic [15:0] nvm_start_word,
    input wire logic [15:0] nvm_stop_word,
    input wire logic [15:0] nvm_phase_word,
    input wire logic [15:0] nvm_gain_word,
    output logic [15:0] start_word,
    output logic [15:0] stop_word,
    output logic [15:0] phase_word,
    output logic [15:0] gain_word,
    output logic [7:0] start_applied,
    output logic [7:0] stop_applied,
    output logic [8:0] phase_delay_deg,
    output logic phase_write_locked,
    output logic convert_en,
    output logic input_undervoltage_fault,
    output logic off_low_input
);
    typedef enum logic [1:0] {
        L_IDLE = 2'b01,
        L_WAIT = 2'b10
    } link_fsm_t;

    typedef struct packed {
        link_fsm_t fsm;
        logic req_tgl;
        logic ack_seen;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
        logic ready;
        logic rsp_valid;
        logic [15:0] rsp_rdata;
        logic rsp_invalid;
        logic rsp_denied;
        logic rsp_unmapped;
    } link_state_t;

    typedef struct packed {
        logic req_seen;
        logic ack_tgl;
        logic [15:0] rdata;
        logic invalid;
        logic denied;
        logic unmapped;
        logic [15:0] start_w;
        logic [15:0] stop_w;
        logic [15:0] phase_w;
        logic [15:0] gain_w;
        logic [7:0] start_app;
        logic [7:0] stop_app;
        logic [8:0] phase_deg;
        logic lock;
        logic load_pend;
        logic mask;
        logic fault;
        logic conv_en;
        logic off_low;
    } core_state_t;

    link_state_t lk_q;
    link_state_t lk_d;
    core_state_t cs_q;
    core_state_t cs_d;
    logic req_sync;
    logic ack_sync;

    // signed mantissa times 2^(exp+fb), floored; returns {fraction lost, negative, value}
    function automatic logic [33:0] lin_scale(input logic [15:0] w, input logic [6:0] fb);
        logic [6:0] e2;
        logic [4:0] sh;
        logic [31:0] mag;
        logic [31:0] q;
        logic frac;
        e2 = {{2{w[thr_phase_pkg::EXP_MSB]}}, w[thr_phase_pkg::EXP_MSB:thr_phase_pkg::EXP_LSB]} + fb;
        mag = {21'h000000, w[thr_phase_pkg::MAN_MSB:thr_phase_pkg::MAN_LSB]};
        sh = 5'h00;
        frac = 1'b0;
        q = 32'h0000_0000;
        if (!e2[6]) begin
            if (e2 > 7'h14) begin
                q = (mag == 32'h0000_0000) ? 32'h0000_0000 : 32'hffff_ffff;
            end else begin
                q = mag << e2[4:0];
            end
        end else begin
            sh = 5'((~e2) + 7'h01);
            q = mag >> sh;
            frac = (mag & ((32'h0000_0001 << sh) - 32'h0000_0001)) != 32'h0000_0000;
        end
        return {frac, w[thr_phase_pkg::MAN_MSB], q};
    endfunction

    // range check against [lo, max] with floor to the quarter volt grid
    function automatic logic [8:0] thr_check(input logic [15:0] w, input logic [31:0] lo);
        logic [33:0] r;
        logic ok;
        r = lin_scale(w, thr_phase_pkg::THR_FRAC_BITS);
        ok = !r[32] && r[31:0] >= lo &&
             (r[31:0] < thr_phase_pkg::THR_MAX_Q || (r[31:0] == thr_phase_pkg::THR_MAX_Q && !r[33]));
        return {ok, r[7:0]};
    endfunction

    // phase delay in degrees from size and order
    function automatic logic [8:0] phase_deg(input logic [15:0] w);
        logic [3:0] order;
        logic [8:0] step;
        order = w[thr_phase_pkg::PH_ORDER_MSB:thr_phase_pkg::PH_ORDER_LSB];
        case (w[thr_phase_pkg::PH_SIZE_MSB:thr_phase_pkg::PH_SIZE_LSB])
            4'h2: step = thr_phase_pkg::STEP_SIZE2;
            4'h3: step = thr_phase_pkg::STEP_SIZE3;
            4'h4: step = thr_phase_pkg::STEP_SIZE4;
            default: step = 9'h000;
        endcase
        return 9'(step * {5'h00, order});
    endfunction

    function automatic logic phase_ok(input logic [15:0] w);
        logic [3:0] size;
        size = w[thr_phase_pkg::PH_SIZE_MSB:thr_phase_pkg::PH_SIZE_LSB];
        return size >= thr_phase_pkg::PH_SIZE_MIN && size <= thr_phase_pkg::PH_SIZE_MAX &&
               w[thr_phase_pkg::PH_ORDER_MSB:thr_phase_pkg::PH_ORDER_LSB] < size;
    endfunction

    // gain restore: nearest 1/64, clamped, exponent forced to its fixed code
    function automatic logic [15:0] gain_restore(input logic [15:0] w);
        logic [33:0] r;
        logic [31:0] n;
        r = lin_scale(w, thr_phase_pkg::GAIN_FRAC_BITS);
        n = (r[31:0] >> 1) + {31'h0000_0000, r[0]};
        if (r[32]) begin
            n = 32'h0000_0000;
        end else if (n > thr_phase_pkg::GAIN_NVM_MAX) begin
            n = thr_phase_pkg::GAIN_NVM_MAX;
        end
        return {thr_phase_pkg::GAIN_EXP_RESET, 3'h0, n[6:0], 1'b0};
    endfunction

    // link side: capture a request, hand it over by toggle, wait for the answer
    bit_sync #(.W(1)) ack_sync_i (
        .clk(pmbus_clk),
        .arst_n(arst_n),
        .d(cs_q.ack_tgl),
        .q(ack_sync)
    );

    always_comb begin
        lk_d = lk_q;
        lk_d.rsp_valid = 1'b0;
        case (lk_q.fsm)
            L_IDLE: begin
                if (cmd_valid) begin
                    lk_d.write = cmd_write;
                    lk_d.code = cmd_code;
                    lk_d.wdata = cmd_wdata;
                    lk_d.req_tgl = ~lk_q.req_tgl;
                    lk_d.ready = 1'b0;
                    lk_d.fsm = L_WAIT;
                end
            end
            L_WAIT: begin
                if (ack_sync != lk_q.ack_seen) begin
                    lk_d.ack_seen = ack_sync;
                    lk_d.rsp_valid = 1'b1;
                    lk_d.rsp_rdata = cs_q.rdata;
                    lk_d.rsp_invalid = cs_q.invalid;
                    lk_d.rsp_denied = cs_q.denied;
                    lk_d.rsp_unmapped = cs_q.unmapped;
                    lk_d.ready = 1'b1;
                    lk_d.fsm = L_IDLE;
                end
            end
            default: begin
                lk_d.fsm = L_IDLE;
                lk_d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pmbus_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_q <= '{fsm: L_IDLE, ready: 1'b1, default: '0};
        end else begin
            lk_q <= lk_d;
        end
    end

    // core side: register file, nvm load, input voltage supervision
    bit_sync #(.W(1)) req_sync_i (
        .clk(core_clk),
        .arst_n(arst_n),
        .d(lk_q.req_tgl),
        .q(req_sync)
    );

    always_comb begin
        logic [8:0] chk;
        logic [33:0] gr;
        logic [15:0] wd;
        logic below_stop;
        logic reach_start;
        chk = 9'h000;
        gr = '0;
        wd = lk_q.wdata;
        cs_d = cs_q;
        below_stop = vin_quarter_v < cs_q.stop_app;
        reach_start = !cs_q.load_pend && vin_quarter_v >= cs_q.start_app;

        // nvm image: first cycle after reset, and on every restore request
        if (cs_q.load_pend || restore_req) begin
            cs_d.start_w = {thr_phase_pkg::THR_EXP_RESET,
                            nvm_start_word[thr_phase_pkg::MAN_MSB:thr_phase_pkg::MAN_LSB]};
            cs_d.stop_w = {thr_phase_pkg::THR_EXP_RESET,
                           nvm_stop_word[thr_phase_pkg::MAN_MSB:thr_phase_pkg::MAN_LSB]};
            chk = thr_check(cs_d.start_w, thr_phase_pkg::START_MIN_Q);
            cs_d.start_app = chk[8] ? chk[7:0] : thr_phase_pkg::START_MIN_Q[7:0];
            chk = thr_check(cs_d.stop_w, thr_phase_pkg::STOP_MIN_Q);
            cs_d.stop_app = chk[8] ? chk[7:0] : thr_phase_pkg::STOP_MIN_Q[7:0];
            cs_d.gain_w = gain_restore(nvm_gain_word);
            if (phase_ok(nvm_phase_word)) begin
                cs_d.phase_w = {4'h0, nvm_phase_word[thr_phase_pkg::PH_GROUP_MSB:0]};
                cs_d.phase_deg = phase_deg(nvm_phase_word);
            end
            cs_d.load_pend = 1'b0;
            if (cs_q.load_pend) begin
                cs_d.lock = stack_multi;
            end
        end

        // command from the link side
        if (req_sync != cs_q.req_seen) begin
            cs_d.req_seen = req_sync;
            cs_d.ack_tgl = ~cs_q.ack_tgl;
            cs_d.invalid = 1'b0;
            cs_d.denied = 1'b0;
            cs_d.unmapped = 1'b0;
            cs_d.rdata = 16'h0000;
            if (lk_q.code == thr_phase_pkg::CMD_START_THR) begin
                chk = thr_check(wd, thr_phase_pkg::START_MIN_Q);
                if (lk_q.write && chk[8]) begin
                    cs_d.start_w = wd;
                    cs_d.start_app = chk[7:0];
                end
                cs_d.invalid = lk_q.write && !chk[8];
                cs_d.rdata = lk_q.write ? 16'h0000 : cs_q.start_w;
            end else if (lk_q.code == thr_phase_pkg::CMD_STOP_THR) begin
                chk = thr_check(wd, thr_phase_pkg::STOP_MIN_Q);
                if (lk_q.write && chk[8]) begin
                    cs_d.stop_w = wd;
                    cs_d.stop_app = chk[7:0];
                end
                cs_d.invalid = lk_q.write && !chk[8];
                cs_d.rdata = lk_q.write ? 16'h0000 : cs_q.stop_w;
            end else if (lk_q.code == thr_phase_pkg::CMD_PHASE) begin
                if (lk_q.write && cs_q.lock) begin
                    cs_d.denied = 1'b1;
                end else if (lk_q.write && !phase_ok(wd)) begin
                    cs_d.invalid = 1'b1;
                end else if (lk_q.write) begin
                    cs_d.phase_w = {4'h0, wd[thr_phase_pkg::PH_GROUP_MSB:0]};
                    cs_d.phase_deg = phase_deg(wd);
                end
                cs_d.rdata = lk_q.write ? 16'h0000 : cs_q.phase_w;
            end else if (lk_q.code == thr_phase_pkg::CMD_GAIN) begin
                gr = lin_scale(wd, thr_phase_pkg::GAIN_FRAC_BITS);
                if (lk_q.write && !gr[32] && (gr[31:0] < thr_phase_pkg::GAIN_MAX_Q ||
                    (gr[31:0] == thr_phase_pkg::GAIN_MAX_Q && !gr[33]))) begin
                    cs_d.gain_w = wd;
                end else if (lk_q.write) begin
                    cs_d.invalid = 1'b1;
                end
                cs_d.rdata = lk_q.write ? 16'h0000 : cs_q.gain_w;
            end else begin
                cs_d.unmapped = 1'b1;
            end
        end
        // supervision on the applied grid values; the load cycle still holds reset thresholds
        if (!cs_q.load_pend && vin_quarter_v > cs_q.start_app) begin
            cs_d.mask = 1'b0;
        end
        cs_d.fault = below_stop && !cs_q.mask;
        if (!enable_ok || below_stop) begin
            cs_d.conv_en = 1'b0;
        end else if (reach_start) begin
            cs_d.conv_en = 1'b1;
        end
        if (enable_ok && below_stop) begin
            cs_d.off_low = 1'b1;
        end else if (clear_status) begin
            cs_d.off_low = 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_q <= '{start_w: thr_phase_pkg::START_RESET,
                      stop_w: thr_phase_pkg::STOP_RESET,
                      phase_w: thr_phase_pkg::PHASE_RESET,
                      gain_w: thr_phase_pkg::GAIN_RESET,
                      start_app: thr_phase_pkg::START_MIN_Q[7:0],
                      stop_app: thr_phase_pkg::STOP_MIN_Q[7:0],
                      lock: 1'b1,
                      load_pend: 1'b1,
                      mask: 1'b1,
                      default: '0};
        end else begin
            cs_q <= cs_d;
        end
    end

    assign cmd_ready = lk_q.ready;
    assign rsp_valid = lk_q.rsp_valid;
    assign rsp_rdata = lk_q.rsp_rdata;
    assign rsp_invalid = lk_q.rsp_invalid;
    assign rsp_denied = lk_q.rsp_denied;
    assign rsp_unmapped = lk_q.rsp_unmapped;
    assign start_word = cs_q.start_w;
    assign stop_word = cs_q.stop_w;
    assign phase_word = cs_q.phase_w;
    assign gain_word = cs_q.gain_w;
    assign start_applied = cs_q.start_app;
    assign stop_applied = cs_q.stop_app;
    assign phase_delay_deg = cs_q.phase_deg;
    assign phase_write_locked = cs_q.lock;
    assign convert_en = cs_q.conv_en;
    assign input_undervoltage_fault = cs_q.fault;
    assign off_low_input = cs_q.off_low;
endmodule

// ==== rtl/thr_phase_pkg.sv ====
// constants for the input threshold, phase placement and current gain commands
package thr_phase_pkg;
    // command codes on the word port
    localparam logic [7:0] CMD_START_THR = 8'h35;
    localparam logic [7:0] CMD_STOP_THR = 8'h36;
    localparam logic [7:0] CMD_PHASE = 8'h37;
    localparam logic [7:0] CMD_GAIN = 8'h38;

    // linear word layout
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int MAN_LSB = 0;

    // phase placement layout
    localparam int PH_ZERO_MSB = 15;
    localparam int PH_ZERO_LSB = 12;
    localparam int PH_GROUP_MSB = 11;
    localparam int PH_GROUP_LSB = 8;
    localparam int PH_SIZE_MSB = 7;
    localparam int PH_SIZE_LSB = 4;
    localparam int PH_ORDER_MSB = 3;
    localparam int PH_ORDER_LSB = 0;
    localparam logic [3:0] PH_SIZE_MIN = 4'h1;
    localparam logic [3:0] PH_SIZE_MAX = 4'h4;

    // exponent reset codes
    localparam logic [4:0] THR_EXP_RESET = 5'h1e;
    localparam logic [4:0] GAIN_EXP_RESET = 5'h19;

    // power-on values before the nvm image loads
    localparam logic [15:0] START_RESET = 16'hf000;
    localparam logic [15:0] STOP_RESET = 16'hf000;
    localparam logic [15:0] PHASE_RESET = 16'h0010;
    localparam logic [15:0] GAIN_RESET = 16'hc880;

    // threshold grid in quarter volts
    localparam logic [6:0] THR_FRAC_BITS = 7'sd2;
    localparam logic [31:0] START_MIN_Q = 32'h0000_000a;
    localparam logic [31:0] STOP_MIN_Q = 32'h0000_0009;
    localparam logic [31:0] THR_MAX_Q = 32'h0000_0049;

    // gain in 1/128 units, nvm grid in 1/64 units
    localparam logic [6:0] GAIN_FRAC_BITS = 7'sd7;
    localparam logic [31:0] GAIN_MAX_Q = 32'h0000_00fe;
    localparam logic [31:0] GAIN_NVM_MAX = 32'h0000_007f;

    // phase step per order, in degrees
    localparam logic [8:0] STEP_SIZE2 = 9'h0b4;
    localparam logic [8:0] STEP_SIZE3 = 9'h078;
    localparam logic [8:0] STEP_SIZE4 = 9'h05a;
endpackage

// ==== rtl/bit_sync.sv ====
// two-flop synchroniser for level and toggle signals
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule

// ==== verif/input_threshold_phase_regs_sva.sv ====
// assertion checker for the threshold and phase command registers
`timescale 1ns/1ps
module input_threshold_phase_regs_sva (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic pmbus_clk,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] vin_quarter_v,
    input wire logic enable_ok,
    input wire logic [15:0] phase_word,
    input wire logic [7:0] start_applied,
    input wire logic [7:0] stop_applied,
    input wire logic phase_write_locked,
    input wire logic convert_en,
    input wire logic input_undervoltage_fault,
    input wire logic off_low_input
);
    logic seen_q;
    logic [1:0] age_q;
    // input has been above start since reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_q <= 1'b0;
            age_q <= 2'h0;
        end else begin
            if (age_q != 2'h0 && vin_quarter_v > start_applied) seen_q <= 1'b1;
            if (age_q != 2'h2) age_q <= age_q + 2'h1;
        end
    end
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_answer;
        ##[4:14] rsp_valid;
    endsequence
    AST_ANSWER_BOUND: assert property (@(posedge pmbus_clk) disable iff (!arst_n) s_take |-> s_answer)
        else $error("no answer after request");
    AST_BUSY: assert property (@(posedge pmbus_clk) disable iff (!arst_n) s_take |=> (!cmd_ready until rsp_valid))
        else $error("ready before answer");
    AST_PULSE: assert property (@(posedge pmbus_clk) disable iff (!arst_n) rsp_valid |=> !rsp_valid)
        else $error("answer pulse too long");
    AST_PHASE_TOP: assert property (@(posedge core_clk) disable iff (!arst_n) phase_word[15:12] == 4'h0)
        else $error("phase top bits not zero");
    AST_START_GRID: assert property (@(posedge core_clk) disable iff (!arst_n) start_applied inside {[8'h0a:8'h49]})
        else $error("start applied off grid");
    AST_STOP_GRID: assert property (@(posedge core_clk) disable iff (!arst_n) stop_applied inside {[8'h09:8'h49]})
        else $error("stop applied off grid");
    AST_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) age_q == 2'h2 |-> $stable(phase_write_locked))
        else $error("lock changed after power-on");
    AST_FAULT_MASK: assert property (@(posedge core_clk) disable iff (!arst_n) !seen_q |=> !input_undervoltage_fault)
        else $error("fault while masked");
    AST_FAULT_LEVEL: assert property (@(posedge core_clk) disable iff (!arst_n)
        seen_q && vin_quarter_v < stop_applied |=> input_undervoltage_fault) else $error("fault missing");
    AST_OFF_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
        enable_ok && vin_quarter_v < stop_applied |=> off_low_input) else $error("off status missing");
    AST_CONV_STOP: assert property (@(posedge core_clk) disable iff (!arst_n)
        !enable_ok || vin_quarter_v < stop_applied |=> !convert_en) else $error("conversion not stopped");
    AST_CONV_START: assert property (@(posedge core_clk) disable iff (!arst_n)
        age_q != 2'h0 && enable_ok && vin_quarter_v >= start_applied && vin_quarter_v >= stop_applied |=> convert_en)
        else $error("conversion not started");
endmodule
bind input_threshold_phase_regs input_threshold_phase_regs_sva u_sva (
    .core_clk(core_clk), .arst_n(arst_n), .pmbus_clk(pmbus_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .vin_quarter_v(vin_quarter_v), .enable_ok(enable_ok), .phase_word(phase_word),
    .start_applied(start_applied), .stop_applied(stop_applied), .phase_write_locked(phase_write_locked),
    .convert_en(convert_en), .input_undervoltage_fault(input_undervoltage_fault), .off_low_input(off_low_input)
);

// ==== verif/pmbus_host_model.sv ====
// host controller model issuing word reads and writes on the command port
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic pmbus_clk,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_invalid,
    input wire logic rsp_denied,
    input wire logic rsp_unmapped,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // one outstanding word transfer; gap idles first, lost answers set tmo
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, input int gap,
                        output logic [15:0] rd, output logic [2:0] fl, output bit tmo);
        tmo = 1'b1;
        rd = 16'h0000;
        fl = 3'h0;
        repeat (gap + 1) @(posedge pmbus_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_wdata <= wd;
        for (int n = 0; n < 20; n++) begin
            @(posedge pmbus_clk);
            if (cmd_ready === 1'b1) break;
        end
        // released lines carry junk, not the last word
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~wd;
        for (int n = 0; n < 20; n++) begin
            @(posedge pmbus_clk);
            if (rsp_valid === 1'b1) begin
                rd = rsp_rdata;
                fl = {rsp_invalid, rsp_denied, rsp_unmapped};
                tmo = 1'b0;
                break;
            end
        end
    endtask
endmodule

// ==== verif/input_threshold_phase_regs_test.sv ====
// self-checking bench for the threshold and phase command registers
`timescale 1ns/1ps
module input_threshold_phase_regs_test;
    logic core_clk = 1'b0;
    logic pmbus_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_invalid, rsp_denied, rsp_unmapped;
    logic [7:0] cmd_code, start_applied, stop_applied;
    logic [15:0] cmd_wdata, rsp_rdata, start_word, stop_word, phase_word, gain_word;
    logic [8:0] phase_delay_deg;
    logic phase_write_locked, convert_en, input_undervoltage_fault, off_low_input;
    logic [7:0] vin_quarter_v = 8'h00;
    logic enable_ok = 1'b0;
    logic stack_multi = 1'b0;
    logic restore_req = 1'b0;
    logic clear_status = 1'b0;
    logic [15:0] nvm_start_word = 16'h0028;
    logic [15:0] nvm_stop_word = 16'h0024;
    logic [15:0] nvm_phase_word = 16'h0321;
    logic [15:0] nvm_gain_word = 16'hc10b;
    logic [31:0] lfsr = 32'h99e2;
    logic [15:0] rd;
    logic [2:0] fl;
    bit tmo;
    int err_total = 0;
    int n_checks = 0;
    localparam logic [15:0] TW[10] = '{16'hf032, 16'he865, 16'hf009, 16'hf049, 16'hf04a, 16'hf7ff, 16'he893,
                                        16'hf009, 16'hf008, 16'hf028};

    always #12.5 core_clk = ~core_clk;
    always #24 pmbus_clk = ~pmbus_clk;

    input_threshold_phase_regs uut (.*);
    pmbus_host_model u_host (.*);

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // quarter-volt floor of a linear word, -1 when refused
    function automatic int thr_q(input logic [15:0] w, input int lo);
        int e, m, q;
        e = $signed(w[15:11]) + 2;
        m = $signed(w[10:0]);
        q = (e >= 0) ? (m <<< e) : (m >>> -e);
        if (m < 0 || q < lo || q > 73 || (q == 73 && e < 0 && (m & ((1 << -e) - 1)) != 0)) return -1;
        return q;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] code, input logic [15:0] wd);
        u_host.xfer(wr, code, wd, int'(rnd() % 3), rd, fl, tmo);
        if (tmo) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic do_reset(input logic multi);
        @(posedge core_clk);
        arst_n <= 1'b0;
        stack_multi <= multi;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic setv(input logic [7:0] v, input logic en, input logic clr, input logic rs);
        @(posedge core_clk);
        vin_quarter_v <= v;
        enable_ok <= en;
        clear_status <= clr;
        restore_req <= rs;
        @(posedge core_clk);
        clear_status <= 1'b0;
        restore_req <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    initial begin
        int c, q;
        int a[2];
        logic [15:0] w[2];
        logic [15:0] pw;
        logic [31:0] r;
        do_reset(1'b0);
        chk("start word", start_word, 32'hf028);
        chk("stop word", stop_word, 32'hf024);
        chk("start applied", start_applied, 32'h28);
        chk("stop applied", stop_applied, 32'h24);
        chk("gain word", gain_word, 32'hc886);
        chk("phase delay", phase_delay_deg, 32'hb4);
        chk("phase lock", phase_write_locked, 32'h0);
        a = '{40, 36};
        w = '{16'hf028, 16'hf024};
        for (int i = 0; i < 22; i++) begin
            r = rnd();
            c = (i < 10) ? int'(i >= 7) : int'(r[8]);
            pw = (i < 10) ? TW[i] : {5'h1e, 4'h0, r[6:0]};
            q = thr_q(pw, c ? 9 : 10);
            bus(1'b1, 8'h35 + 8'(c), pw);
            chk("thr refused", fl[2], 32'(q < 0));
            if (q >= 0) begin
                a[c] = q;
                w[c] = pw;
            end
            chk("thr applied", c ? stop_applied : start_applied, 32'(a[c]));
            bus(1'b0, 8'h35 + 8'(c), 16'h0000);
            chk("thr read", rd, 32'(w[c]));
        end
        bus(1'b1, 8'h35, 16'hf028);
        bus(1'b1, 8'h36, 16'hf024);
        setv(8'h1e, 1'b1, 1'b0, 1'b0);
        chk("fault masked", input_undervoltage_fault, 32'h0);
        chk("off low", off_low_input, 32'h1);
        chk("conv below", convert_en, 32'h0);
        setv(8'h29, 1'b1, 1'b1, 1'b0);
        chk("conv above", convert_en, 32'h1);
        chk("off cleared", off_low_input, 32'h0);
        setv(8'h1e, 1'b1, 1'b0, 1'b0);
        chk("fault armed", input_undervoltage_fault, 32'h1);
        nvm_start_word <= 16'h002a;
        setv(8'h1e, 1'b0, 1'b0, 1'b1);
        setv(8'h1e, 1'b1, 1'b0, 1'b0);
        chk("fault kept", input_undervoltage_fault, 32'h1);
        chk("restored start", start_applied, 32'h2a);
        for (int s = 1; s <= 4; s++) begin
            for (int o = 0; o < s; o++) begin
                r = rnd();
                pw = {4'h0, r[3:0], s[3:0], o[3:0]};
                bus(1'b1, 8'h37, pw);
                repeat (3) @(posedge core_clk);
                chk("phase flags", fl, 32'h0);
                chk("phase word", phase_word, 32'(pw));
                chk("phase deg", phase_delay_deg, 32'(360 / s * o));
            end
        end
        bus(1'b1, 8'h37, 16'ha932);
        chk("phase top", phase_word, 32'h0932);
        bus(1'b1, 8'h37, 16'h0500);
        chk("size zero", fl, 32'h4);
        bus(1'b1, 8'h37, 16'h0050);
        chk("size five", fl, 32'h4);
        bus(1'b1, 8'h37, 16'h0022);
        chk("order size", fl, 32'h4);
        chk("phase kept", phase_word, 32'h0932);
        @(posedge core_clk);
        stack_multi <= 1'b1;
        bus(1'b1, 8'h37, 16'h0010);
        chk("late stack", phase_word, 32'h0010);
        bus(1'b1, 8'h38, 16'hc880);
        chk("gain one", gain_word, 32'hc880);
        bus(1'b1, 8'h38, 16'hc8ff);
        chk("gain high", fl, 32'h4);
        bus(1'b0, 8'h38, 16'h0000);
        chk("gain read", rd, 32'hc880);
        bus(1'b0, 8'h40, 16'h0000);
        chk("unmapped", {fl, rd}, 32'h10000);
        do_reset(1'b1);
        chk("locked", phase_write_locked, 32'h1);
        chk("mask rearmed", input_undervoltage_fault, 32'h0);
        bus(1'b1, 8'h37, 16'h0021);
        chk("denied", fl, 32'h2);
        bus(1'b0, 8'h37, 16'h0000);
        chk("phase read", rd, 32'h0321);
        stop_test();
    end
endmodule
